// file: design/viu_pkg.sv
// shared constants and carrier types of the vectored interrupt enable unit
package viu_pkg;

  // source count and arbitration slots
  localparam int unsigned NUM_SRC      = 21;
  localparam int unsigned IDX_W        = 5;
  localparam logic [4:0]  IDX_EXT0     = 5'h00;
  localparam logic [4:0]  IDX_EXT1     = 5'h02;
  localparam logic [4:0]  IDX_TIMER2   = 5'h05;
  localparam logic [4:0]  IDX_SPI      = 5'h06;
  localparam logic [4:0]  IDX_EXT_LO   = 5'h07;
  localparam logic [4:0]  IDX_EXT2_LO  = 5'h0f;
  localparam logic [4:0]  IDX_RESERVED = 5'h11;
  localparam logic [4:0]  IDX_TIMER5   = 5'h14;

  // vector map
  localparam logic [15:0] VEC_RESET    = 16'h0000;
  localparam logic [15:0] VEC_BASE     = 16'h0003;
  localparam int unsigned VEC_SHIFT    = 3;

  // special-function addresses
  localparam logic [7:0]  ADDR_ENABLE  = 8'ha8;
  localparam logic [7:0]  ADDR_PRIO    = 8'hb8;
  localparam logic [7:0]  ADDR_EXT_EN1 = 8'he6;
  localparam logic [7:0]  ADDR_EXT_PR1 = 8'hf6;
  localparam logic [7:0]  ADDR_EXT_EN2 = 8'he7;
  localparam logic [7:0]  ADDR_EXT_PR2 = 8'hf7;

  // field positions in the primary enable register
  localparam int unsigned BIT_GLOBAL   = 7;
  localparam int unsigned BIT_SERIAL   = 6;
  localparam int unsigned BIT_TIMER2   = 5;
  localparam int unsigned BIT_UART_A   = 4;
  localparam int unsigned BIT_TIMER1   = 3;
  localparam int unsigned BIT_EXT1     = 2;
  localparam int unsigned BIT_TIMER0   = 1;
  localparam int unsigned BIT_EXT0     = 0;
  localparam int unsigned BIT_RSV_EXT2 = 2;

  // values after reset
  localparam logic [7:0]  RST_ENABLE   = 8'h00;
  localparam logic [7:0]  RST_PRIO     = 8'h00;
  localparam logic [7:0]  RST_EXT      = 8'h00;
  localparam logic [7:0]  PRIO_RD_ONE  = 8'h80;
  localparam logic [7:0]  RST_RDATA    = 8'h00;

  // detect latency in cycles from pending flag to request
  localparam int unsigned DETECT_CYC   = 1;

  // pending flags as raised by the peripherals
  typedef struct packed {
    logic        timer5_high_overflow_flag;
    logic        timer5_low_overflow_flag;
    logic        timer2_high_overflow_flag;
    logic        timer2_low_overflow_flag;
    logic [3:0]  spi_flags;
    logic [20:0] single_flags;
  } viu_pend_s;

  // request toward the core
  typedef struct packed {
    logic        req;
    logic        high;
    logic [15:0] vector;
  } viu_irq_s;

  // service nesting states
  typedef enum logic [3:0] {
    SVC_IDLE = 4'b0001,
    SVC_LOW  = 4'b0010,
    SVC_HIGH = 4'b0100,
    SVC_BOTH = 4'b1000
  } viu_svc_e;

endpackage

// file: design/viu_arbiter.sv
// fixed-order arbiter across two priority levels
`timescale 1ns/1ps
module viu_arbiter (
  // candidate requests per level
  input  wire logic [20:0] hi_req_i,
  input  wire logic [20:0] lo_req_i,
  input  wire logic        allow_low_i,
  // chosen source
  output logic             valid_o,
  output logic             high_o,
  output logic [4:0]       idx_o
);

  // lowest set index wins, order 0 first
  function automatic logic [4:0] first_set(input logic [20:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 20; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // high level beats low level, then fixed order
  always_comb begin
    valid_o = 1'b0;
    high_o  = 1'b0;
    idx_o   = 5'h00;
    if (|hi_req_i) begin
      valid_o = 1'b1;
      high_o  = 1'b1;
      idx_o   = first_set(hi_req_i);
    end else if (allow_low_i && (|lo_req_i)) begin
      valid_o = 1'b1;
      idx_o   = first_set(lo_req_i);
    end
  end

endmodule

// file: design/viu_ctrl.sv
// enable, priority registers and vectoring for the interrupt unit
// Notes on behaviour
// R1 - vectors 8 bytes apart, slot 17 reserved
// R2 - equal level ties broken by fixed order
// R3 - timer5 request from either overflow flag
// R4 - global enable clear blocks every request
// R5 - global enable set passes unmasked sources only
// R6 - mask bit 6 gates serial peripheral requests
// R7 - mask bit 5 gates either timer2 flag
// R8 - mask bit 4 gates first uart request
// R9 - mask bit 3 gates timer1 overflow
// R10 - mask bit 2 gates external pin 1
// R11 - mask bit 1 gates timer0 overflow
// R12 - mask bit 0 gates external pin 0
// R13 - enable register at 0xa8, bit-addressable, clears
// R14 - high preempts low, high never preempted
// R15 - simultaneous requests: higher level first
// R16 - flags pend regardless of masks
// R17 - requests sampled and decoded every cycle
// R18 - reset enters vector zero above all
// R19 - orders 7-20 use extended enable and priority
`timescale 1ns/1ps
module viu_ctrl (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               srst_i,
  // special-function byte access, one cycle strobes
  input  wire logic [7:0]         sfr_addr_i,
  input  wire logic               sfr_wr_i,
  input  wire logic [7:0]         sfr_wdata_i,
  output logic [7:0]              sfr_rdata_o,
  // single bit write for bit-addressable registers
  input  wire logic               sfr_bit_wr_i,
  input  wire logic [7:0]         sfr_bit_addr_i,
  input  wire logic               sfr_bit_val_i,
  // pending flags from peripherals
  input  wire viu_pkg::viu_pend_s pend_i,
  // core handshake
  input  wire logic               irq_ack_i,
  input  wire logic               reti_i,
  output viu_pkg::viu_irq_s       irq_o,
  output logic [7:0]              enable_mask_o
);

  // register state
  logic [7:0]         mask_q, mask_d;      // interrupt_enable_mask
  logic [7:0]         ip_q, ip_d;          // primary priority bits, one selects high level
  logic [7:0]         xmask1_q, xmask1_d;  // extended_mask_reg_one
  logic [7:0]         xmask2_q, xmask2_d;  // extended_mask_reg_two
  logic [7:0]         xprio1_q, xprio1_d;  // extended_priority_reg_one
  logic [7:0]         xprio2_q, xprio2_d;  // extended_priority_reg_two
  logic [7:0]         rdata_q, rdata_d;  // registered read data
  viu_pkg::viu_svc_e  svc_q, svc_d;      // nesting of service routines
  viu_pkg::viu_irq_s  irq_q, irq_d;      // request toward the core

  // decoded vectors
  logic [20:0] pend;      // merged pending per slot
  logic [20:0] en;        // enable per slot
  logic [20:0] pr;        // priority per slot
  logic [20:0] cand;      // gated requests
  logic        global_irq_enable;
  logic        arb_valid;
  logic        arb_high;
  logic [4:0]  arb_idx;
  logic        allow_low;
  logic        allow_any;

  // bit write hits the byte when the upper five address bits match
  function automatic logic bit_hit(input logic [7:0] ba,
                                   input logic [7:0] base);
    return ba[7:3] == base[7:3];
  endfunction

  // read mux; unmapped addresses read zero
  function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                        input logic [7:0] im,
                                        input logic [7:0] ip,
                                        input logic [7:0] e1,
                                        input logic [7:0] e2,
                                        input logic [7:0] p1,
                                        input logic [7:0] p2);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      viu_pkg::ADDR_ENABLE:  r = im;
      viu_pkg::ADDR_PRIO:    r = ip | viu_pkg::PRIO_RD_ONE;
      viu_pkg::ADDR_EXT_EN1: r = e1;
      viu_pkg::ADDR_EXT_EN2: r = e2;
      viu_pkg::ADDR_EXT_PR1: r = p1;
      viu_pkg::ADDR_EXT_PR2: r = p2;
      default:               r = 8'h00;
    endcase
    return r;
  endfunction

  assign global_irq_enable = mask_q[viu_pkg::BIT_GLOBAL];

  // merge multi-flag sources into one pending bit per slot
  always_comb begin
    pend = pend_i.single_flags;
    // R7 either timer2 flag
    pend[viu_pkg::IDX_TIMER2] = pend_i.timer2_high_overflow_flag |
                                pend_i.timer2_low_overflow_flag;
    // R6 any serial flag
    pend[viu_pkg::IDX_SPI]    = |pend_i.spi_flags;
    // R3 either timer5 flag
    pend[viu_pkg::IDX_TIMER5] = pend_i.timer5_high_overflow_flag |
                                pend_i.timer5_low_overflow_flag;
    // R1 reserved slot can never request
    pend[viu_pkg::IDX_RESERVED] = 1'b0;
  end

  // enable and priority bits per arbitration slot
  always_comb begin
    // R6 R7 R8 R9 R10 R11 R12 primary mask bits
    en[6:0]   = mask_q[6:0];
    pr[6:0]   = ip_q[6:0];
    // R19 extended registers by order
    en[14:7]  = xmask1_q;
    pr[14:7]  = xprio1_q;
    en[20:15] = xmask2_q[5:0];
    pr[20:15] = xprio2_q[5:0];
    en[viu_pkg::IDX_RESERVED] = 1'b0;
    pr[viu_pkg::IDX_RESERVED] = 1'b0;
  end

  // R4 R5 global override then per-source mask; R16 flags untouched
  assign cand = global_irq_enable ? (pend & en) : 21'h000000;

  // R14 low work allowed only when no routine runs, high unless high runs
  assign allow_any = (svc_q == viu_pkg::SVC_IDLE);
  assign allow_low = allow_any;

  // R2 R15 level then fixed order
  viu_arbiter u_arb (
    .hi_req_i    ((svc_q == viu_pkg::SVC_IDLE || svc_q == viu_pkg::SVC_LOW)
                  ? (cand & pr) : 21'h000000),
    .lo_req_i    (cand & ~pr),
    .allow_low_i (allow_low),
    .valid_o     (arb_valid),
    .high_o      (arb_high),
    .idx_o       (arb_idx)
  );

  // register writes; byte write wins over a bit write in the same cycle
  always_comb begin
    mask_d   = mask_q;
    ip_d     = ip_q;
    xmask1_d = xmask1_q;
    xmask2_d = xmask2_q;
    xprio1_d = xprio1_q;
    xprio2_d = xprio2_q;
    // R13 single bit writes to the enable register
    if (sfr_bit_wr_i && bit_hit(sfr_bit_addr_i, viu_pkg::ADDR_ENABLE)) begin
      mask_d[sfr_bit_addr_i[2:0]] = sfr_bit_val_i;
    end
    if (sfr_bit_wr_i && bit_hit(sfr_bit_addr_i, viu_pkg::ADDR_PRIO)) begin
      ip_d[sfr_bit_addr_i[2:0]] = sfr_bit_val_i;
    end
    if (sfr_wr_i) begin
      unique case (sfr_addr_i)
        viu_pkg::ADDR_ENABLE:  mask_d   = sfr_wdata_i;
        viu_pkg::ADDR_PRIO:    ip_d     = sfr_wdata_i;
        viu_pkg::ADDR_EXT_EN1: xmask1_d = sfr_wdata_i;
        viu_pkg::ADDR_EXT_EN2: xmask2_d = sfr_wdata_i;
        viu_pkg::ADDR_EXT_PR1: xprio1_d = sfr_wdata_i;
        viu_pkg::ADDR_EXT_PR2: xprio2_d = sfr_wdata_i;
        default: ;
      endcase
    end
    // top priority bit is not stored, it always reads one
    ip_d[7] = 1'b0;
    rdata_d = rd_mux(sfr_addr_i, mask_q, ip_q, xmask1_q, xmask2_q,
                     xprio1_q, xprio2_q);
  end

  // service nesting: ack pushes a level, return pops the newest
  always_comb begin
    svc_d = svc_q;
    unique case (svc_q)
      viu_pkg::SVC_IDLE: begin
        if (irq_ack_i && irq_q.req) begin
          svc_d = irq_q.high ? viu_pkg::SVC_HIGH : viu_pkg::SVC_LOW;
        end
      end
      viu_pkg::SVC_LOW: begin
        // R14 high request preempts a low routine
        if (irq_ack_i && irq_q.req && irq_q.high) begin
          svc_d = viu_pkg::SVC_BOTH;
        end else if (reti_i) begin
          svc_d = viu_pkg::SVC_IDLE;
        end
      end
      viu_pkg::SVC_HIGH: begin
        if (reti_i) begin
          svc_d = viu_pkg::SVC_IDLE;
        end
      end
      viu_pkg::SVC_BOTH: begin
        if (reti_i) begin
          svc_d = viu_pkg::SVC_LOW;
        end
      end
      default: svc_d = viu_pkg::SVC_IDLE;
    endcase
  end

  // R17 decoded anew every cycle; taken request drops for one cycle
  always_comb begin
    irq_d.req    = arb_valid && !(irq_ack_i && irq_q.req);
    irq_d.high   = arb_high;
    // R1 vector is base plus eight bytes per order
    irq_d.vector = viu_pkg::VEC_BASE +
                   16'({arb_idx, 3'b000});
    if (!irq_d.req) begin
      irq_d.high   = 1'b0;
      irq_d.vector = irq_q.vector;
    end
  end

  // plain registering of all state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      // R13 all enable bits clear on reset
      mask_q       <= viu_pkg::RST_ENABLE;
      ip_q         <= viu_pkg::RST_PRIO;
      xmask1_q     <= viu_pkg::RST_EXT;
      xmask2_q     <= viu_pkg::RST_EXT;
      xprio1_q     <= viu_pkg::RST_EXT;
      xprio2_q     <= viu_pkg::RST_EXT;
      rdata_q      <= viu_pkg::RST_RDATA;
      svc_q        <= viu_pkg::SVC_IDLE;
      // R18 reset leaves the core at vector zero
      irq_q.req    <= 1'b0;
      irq_q.high   <= 1'b0;
      irq_q.vector <= viu_pkg::VEC_RESET;
    end else begin
      mask_q   <= mask_d;
      ip_q     <= ip_d;
      xmask1_q <= xmask1_d;
      xmask2_q <= xmask2_d;
      xprio1_q <= xprio1_d;
      xprio2_q <= xprio2_d;
      rdata_q <= rdata_d;
      svc_q   <= svc_d;
      irq_q   <= irq_d;
    end
  end

  assign sfr_rdata_o   = rdata_q;
  assign irq_o         = irq_q;
  assign enable_mask_o = mask_q;

  // checks, all on the system clock
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_global_off_blocks: assert property ( // R4
    !global_irq_enable && !irq_q.req |=> !irq_q.req)
    else $error("request raised with global enable clear");

  a_mask_gate_req: assert property ( // R5
    irq_d.req |-> global_irq_enable && en[arb_idx] && pend[arb_idx])
    else $error("request from a masked source");

  a_vector_spacing: assert property ( // R1
    irq_q.req |-> irq_q.vector[2:0] == 3'h3 &&
                  irq_q.vector <= 16'h00a3 && irq_q.vector != 16'h008b)
    else $error("vector off the eight byte grid");

  a_timer5_either: assert property ( // R3
    global_irq_enable && en[viu_pkg::IDX_TIMER5] &&
    (pend_i.timer5_low_overflow_flag ^ pend_i.timer5_high_overflow_flag)
    |-> cand[viu_pkg::IDX_TIMER5])
    else $error("timer5 flag did not form a candidate");

  a_high_no_preempt: assert property ( // R14
    svc_q == viu_pkg::SVC_HIGH || svc_q == viu_pkg::SVC_BOTH
    |=> !irq_q.req)
    else $error("high routine was offered a request");

  a_high_first: assert property ( // R15
    allow_any && !(irq_ack_i && irq_q.req) &&
    |(cand & pr) && |(cand & ~pr) |=> irq_q.req && irq_q.high)
    else $error("low request won over high");

  a_order_tie: assert property ( // R2
    allow_any && cand[viu_pkg::IDX_EXT0] && cand[viu_pkg::IDX_EXT1] &&
    pr[viu_pkg::IDX_EXT0] == pr[viu_pkg::IDX_EXT1] &&
    !irq_q.req && !(|(cand & pr & ~21'h1))
    |=> irq_q.vector == 16'h0003)
    else $error("tie not broken by fixed order");

  a_detect_cycle: assert property ( // R17
    allow_any && |cand && !(irq_ack_i && irq_q.req)
    ##1 !(irq_ack_i && irq_q.req) |-> irq_q.req)
    else $error("pending request not presented after one cycle");

  a_reset_clear: assert property ( // R13
    $fell(srst_i) |-> mask_q == 8'h00 && irq_q.vector == 16'h0000)
    else $error("enable register not clear after reset");

endmodule

// file: tb/viu_core_model.sv
// behavioural core that takes offered requests and returns later
`timescale 1ns/1ps
module viu_core_model (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  // control from the bench
  input  wire logic              en_i,
  input  wire logic [7:0]        svc_cyc_i,
  // request from the unit, handshake back
  input  wire viu_pkg::viu_irq_s irq_i,
  output logic                   irq_ack_o,
  output logic                   reti_o,
  output logic [1:0]             depth_o
);
  // service timer, reloaded at each entry and return
  logic [7:0] cnt_q;

  // one ack per offered request, one return per ack
  always @(posedge clk_i) begin
    irq_ack_o <= 1'b0;
    reti_o    <= 1'b0;
    if (srst_i) begin
      depth_o <= 2'h0;
      cnt_q   <= 8'h00;
    end else if (depth_o != 2'h0 && cnt_q == 8'h00) begin
      // no ack in a return cycle, so the two never collide
      reti_o  <= 1'b1;
      depth_o <= depth_o - 2'h1;
      cnt_q   <= svc_cyc_i;
    end else begin
      if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
      // ack held off one cycle: req drops after a taken ack
      if (en_i && irq_i.req && !irq_ack_o) begin
        irq_ack_o <= 1'b1;
        depth_o   <= depth_o + 2'h1;
        cnt_q     <= svc_cyc_i;
      end
    end
  end
endmodule

// file: tb/viu_ctrl_test.sv
// self-checking bench for the interrupt enable unit
`timescale 1ns/1ps
module viu_ctrl_test;
  // stimulus, driven at rising edges
  logic               clk_i = 1'b0;
  logic               srst_i = 1'b1;
  logic [7:0]         addr = 8'h00, wdata = 8'h00, baddr = 8'h00;
  logic               wr = 1'b0, bwr = 1'b0, bval = 1'b0;
  logic               core_en = 1'b0;
  viu_pkg::viu_pend_s pend = '0;
  // observed outputs
  logic [7:0]         rdata, emask;
  viu_pkg::viu_irq_s  irq;
  logic               ack, reti;
  logic [1:0]         depth;
  // reference register copies and run state
  logic [7:0]         m_en = 8'h00, m_pr = 8'h80, m_e1 = 8'h00;
  logic [7:0]         m_e2 = 8'h00, m_p1 = 8'h00, m_p2 = 8'h00;
  logic [7:0]         ra [6] = '{8'ha8, 8'hb8, 8'he6, 8'he7, 8'hf6, 8'hf7};
  int                 errors = 0, total_checks = 0, seed = 23, lvl = 0;

  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  viu_ctrl dut_u (.clk_i(clk_i), .srst_i(srst_i), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .sfr_bit_wr_i(bwr), .sfr_bit_addr_i(baddr), .sfr_bit_val_i(bval),
    .pend_i(pend), .irq_ack_i(ack), .reti_i(reti), .irq_o(irq),
    .enable_mask_o(emask));
  viu_core_model core_u (.clk_i(clk_i), .srst_i(srst_i), .en_i(core_en),
    .svc_cyc_i(8'h3c), .irq_i(irq), .irq_ack_o(ack), .reti_o(reti),
    .depth_o(depth));

  // reference: best enabled source, high level first, then order
  function automatic viu_pkg::viu_irq_s predict(input int lv);
    viu_pkg::viu_irq_s r;
    logic [20:0]       act, en, pr;
    int                best;
    r = '0;
    best = -1;
    act = pend.single_flags;
    act[5] = pend.timer2_high_overflow_flag | pend.timer2_low_overflow_flag;
    act[6] = |pend.spi_flags;
    act[20] = pend.timer5_high_overflow_flag | pend.timer5_low_overflow_flag;
    act[17] = 1'b0;
    en = {m_e2[5:0], m_e1, m_en[6:0]} & {21{m_en[7]}};
    pr = {m_p2[5:0], m_p1, m_pr[6:0]};
    for (int h = 1; h >= 0; h--)
      for (int k = 0; k < 21; k++)
        if (best < 0 && act[k] && en[k] && pr[k] == h &&
            (lv == 0 || (lv == 1 && h == 1))) begin
          best = k;
          r.high = 1'(h);
        end
    if (best >= 0) begin
      r.req = 1'b1;
      r.vector = 16'h0003 + 16'(best * 8);
    end
    return r;
  endfunction

  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // vector and level only matter while a request is expected
  task automatic chk_irq(input viu_pkg::viu_irq_s e);
    total_checks++;
    if (irq.req !== e.req ||
        (e.req && {irq.high, irq.vector} !== {e.high, e.vector})) begin
      errors++;
      $display("mismatch irq_o expected %h seen %h", e, irq);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // byte write, taken at the second edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wr <= 1'b1;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
    case (a)
      8'ha8: m_en = d;
      8'hb8: m_pr = d | 8'h80;
      8'he6: m_e1 = d;
      8'he7: m_e2 = d;
      8'hf6: m_p1 = d;
      8'hf7: m_p2 = d;
      default: ;
    endcase
  endtask

  // read data lands one edge after the address
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr <= a;
    @(posedge clk_i);
    @(negedge clk_i);
    chk8("sfr_rdata_o", e, rdata);
  endtask

  task automatic wr_bit(input logic [7:0] a, input logic v);
    @(posedge clk_i);
    bwr <= 1'b1;
    baddr <= a;
    bval <= v;
    @(posedge clk_i);
    bwr <= 1'b0;
    if (a[7:3] == 5'h15) m_en[a[2:0]] = v;
  endtask

  // compare the request n edges after the last change
  task automatic look(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
    chk_irq(predict(lvl));
  endtask

  // bounded wait for the core's nesting depth
  task automatic wait_depth(input logic [1:0] d);
    int n;
    n = 0;
    while (depth !== d && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    if (depth !== d) begin
      errors++;
      $display("mismatch depth expected %h seen %h", d, depth);
      conclude();
    end
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    @(negedge clk_i);
    chk8("vector", 8'h00, irq.vector[7:0]);
    rd_reg(8'ha8, 8'h00);
    rd_reg(8'hb8, 8'h80);
    rd_reg(8'he6, 8'h00);
    // unmapped place keeps nothing
    wr_reg(8'h55, 8'hff);
    rd_reg(8'h55, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      wr_bit(8'ha8 + 8'(i), 1'b1);
      @(negedge clk_i);
      chk8("enable_mask_o", m_en, emask);
    end
    rd_reg(8'ha8, 8'hff);
    $display("test bit writes done");
    @(posedge clk_i);
    pend <= '1;
    for (int b = 0; b < 7; b++) begin
      wr_reg(8'ha8, 8'h80 | (8'h01 << b));
      look(1);
    end
    wr_reg(8'ha8, 8'h7f);
    look(1);
    wr_reg(8'ha8, 8'he0);
    wr_reg(8'he7, 8'h20);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      pend <= 29'(1) << (21 + i);
      look(1);
    end
    $display("test masks done");
    for (int t = 0; t < 60; t++) begin
      foreach (ra[j]) wr_reg(ra[j], 8'($random(seed)));
      @(posedge clk_i);
      pend <= 29'($random(seed) & $random(seed));
      look(2);
    end
    $display("test random arbitration done");
    foreach (ra[j]) wr_reg(ra[j], 8'h00);
    wr_reg(8'hb8, 8'h04);
    wr_reg(8'ha8, 8'h87);
    @(posedge clk_i);
    pend <= 29'h0000001;
    look(1);
    @(posedge clk_i);
    core_en <= 1'b1;
    wait_depth(2'h1);
    lvl = 1;
    look(2);
    @(posedge clk_i);
    pend <= 29'h0000005;
    look(1);
    wait_depth(2'h2);
    lvl = 2;
    @(posedge clk_i);
    pend <= 29'h0000007;
    look(2);
    @(posedge clk_i);
    pend <= 29'h0000001;
    core_en <= 1'b0;
    wait_depth(2'h1);
    lvl = 1;
    look(2);
    wait_depth(2'h0);
    lvl = 0;
    look(2);
    $display("test nesting done");
    conclude();
  end
endmodule
